// *** hw/insn_decoder_defines.svh ***
// byte encodings, limits and field values for the instruction field decoder
`ifndef INSN_DECODER_DEFINES_SVH
`define INSN_DECODER_DEFINES_SVH
`define MAX_INSN_LEN 4'hf
`define PFX_ES 8'h26
`define PFX_CS 8'h2e
`define PFX_SS 8'h36
`define PFX_DS 8'h3e
`define PFX_FS 8'h64
`define PFX_GS 8'h65
`define PFX_OPSZ 8'h66
`define PFX_ADSZ 8'h67
`define PFX_LOCK 8'hf0
`define PFX_REPEAT_WHILE_UNEQUAL 8'hf2
`define PFX_REPE 8'hf3
`define OP_ESCAPE 8'h0f
`define OP_GRP80 8'h80
`define GP_ERROR_CODE 16'h0000
`define SEG_ES 3'h0
`define SEG_CS 3'h1
`define SEG_SS 3'h2
`define SEG_DS 3'h3
`define SEG_FS 3'h4
`define SEG_GS 3'h5
`define MOD_REG 2'h3
`define MOD_NODISP 2'h0
`define MOD_D8 2'h1
`define MOD_DFULL 2'h2
`define RM_SIB 3'h4
`define RM_D32 3'h5
`define RM_D16 3'h6
`define IDX_NONE 3'h4
`define BASE_ESP 3'h4
`define BASE_EBP 3'h5
`endif

// *** hw/insn_decoder_pkg.sv ***
// types shared by the decoder modules
package insn_decoder_pkg;
  typedef enum logic [1:0] {sz_none, sz_1, sz_2, sz_4} fld_size_t;
  typedef struct packed {
    logic fault;
    logic [15:0] error_code;
    logic [3:0] length;
    logic [7:0] opcode0;
    logic [7:0] opcode1;
    logic two_byte;
    logic [2:0] op_ext;
    logic op32;
    logic addr32;
    logic width;
    logic dir;
    logic sign_ext;
    logic [2:0] reg_sel;
    logic reg_is_byte;
    logic [1:0] mode;
    logic [2:0] rm;
    logic rm_is_reg;
    logic has_sib;
    logic [1:0] scale;
    logic [2:0] index;
    logic index_used;
    logic [2:0] base;
    logic base_used;
    logic ea_undefined;
    logic [2:0] seg;
    logic [1:0] seg_select_narrow;
    logic [2:0] seg_select_wide;
    logic seg_wide_valid;
    logic [2:0] spec_sel;
    logic ctl_ok;
    logic dbg_ok;
    logic tst_ok;
    logic lock;
    logic repeat_while_unequal;
    logic repeat_while_equal;
    logic [31:0] disp;
    logic [31:0] imm;
  } decoded_t;
endpackage : insn_decoder_pkg

// *** hw/dec_stream_if.sv ***
// valid/ready carrier for decoded instructions
`timescale 1ns/1ps
interface dec_stream_if;
  import insn_decoder_pkg::*;
  logic valid;
  logic ready;
  decoded_t data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface : dec_stream_if

// *** hw/dec_skid_buffer.sv ***
// two-entry buffer between decoder and execution pipeline
`timescale 1ns/1ps
module dec_skid_buffer
  import insn_decoder_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic resetn,
  dec_stream_if.dst in_s,
  output logic out_valid,
  input wire logic out_ready,
  output decoded_t out_data
);
  if (DEPTH != 2) begin : g_depth_check
    $error("dec_skid_buffer supports depth 2 only");
  end
  typedef struct packed {
    decoded_t [1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } skid_state_t;
  skid_state_t st, next_st;
  logic push, pop;
  assign in_s.ready = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data = st.mem[st.rd];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_s.data;
      next_st.wr = ~st.wr;
    end
    if (pop) next_st.rd = ~st.rd;
    next_st.cnt = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) st <= '0;
    else st <= next_st;
  end
  AST_BUF_HOLD: assert property (@(posedge ref_clk) disable iff (!resetn)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled output word changed");
endmodule : dec_skid_buffer

// *** hw/modrm_decode.sv ***
// addressing-form and scale-index-base field decode
`timescale 1ns/1ps
`include "insn_decoder_defines.svh"
module modrm_decode
  import insn_decoder_pkg::*;
(
  input wire logic [7:0] modrm,
  input wire logic [7:0] sib,
  input wire logic addr32,
  input wire logic [2:0] seg_override,
  input wire logic seg_override_valid,
  output logic has_sib,
  output fld_size_t disp_size,
  output logic [2:0] seg,
  output logic index_used,
  output logic base_used,
  output logic ea_undefined
);
  logic [1:0] md;
  logic [2:0] rm;
  logic [2:0] dseg;
  assign md = modrm[7:6];
  assign rm = modrm[2:0];
  always_comb begin
    has_sib = 1'b0;
    disp_size = sz_none;
    dseg = `SEG_DS;
    index_used = 1'b0;
    base_used = 1'b1;
    ea_undefined = 1'b0;
    if (md == `MOD_REG) begin
      base_used = 1'b0;
    end else if (!addr32) begin
      // 16-bit forms; bp-based default to ss
      if (md == `MOD_D8) disp_size = sz_1;
      else if (md == `MOD_DFULL) disp_size = sz_2;
      else if (rm == `RM_D16) begin
        disp_size = sz_2;
        base_used = 1'b0;
      end
      if (rm == 3'h2 || rm == 3'h3 || (rm == `RM_D16 && md != `MOD_NODISP)) dseg = `SEG_SS;
      index_used = (rm[2] == 1'b0);
    end else begin
      if (md == `MOD_D8) disp_size = sz_1;
      else if (md == `MOD_DFULL) disp_size = sz_4;
      if (rm == `RM_SIB) begin
        has_sib = 1'b1;
        index_used = (sib[5:3] != `IDX_NONE);
        ea_undefined = (sib[5:3] == `IDX_NONE) && (sib[7:6] != 2'h0);
        if (md == `MOD_NODISP && sib[2:0] == `BASE_EBP) begin
          disp_size = sz_4;
          base_used = 1'b0;
        end else if (sib[2:0] == `BASE_ESP || sib[2:0] == `BASE_EBP) dseg = `SEG_SS;
      end else if (md == `MOD_NODISP && rm == `RM_D32) begin
        disp_size = sz_4;
        base_used = 1'b0;
      end else if (rm == `BASE_EBP) dseg = `SEG_SS;
    end
    seg = seg_override_valid ? seg_override : dseg;
  end
endmodule : modrm_decode

// *** hw/insn_field_decoder.sv ***
// byte-serial instruction field decoder, top level
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "insn_decoder_defines.svh"
module insn_field_decoder
  import insn_decoder_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic default_32,
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data,
  output logic dec_valid,
  input wire logic dec_ready,
  output decoded_t dec_data
);
  typedef enum logic [2:0] {st_prefix, st_op2, st_modrm, st_sib, st_dsize, st_disp, st_imm, st_emit} phase_t;
  typedef struct packed {
    phase_t phase;
    decoded_t d;
    logic [2:0] seg_ovr;
    logic seg_ovr_valid;
    logic opsz_flip;
    logic adsz_flip;
    logic [2:0] left;
    logic [2:0] imm_len;
    logic [1:0] shift;
    logic [7:0] sib;
  } dec_state_t;
  dec_state_t st, next_st;
  dec_stream_if out_s ();
  logic take;
  logic has_sib;
  fld_size_t disp_size;
  logic [2:0] seg;
  logic index_used, base_used, ea_undef;
  logic [7:0] modrm_b, sib_b;
  logic op32_eff, addr32_eff;

  function automatic logic [2:0] sz_bytes(input fld_size_t s);
    case (s)
      sz_1: sz_bytes = 3'h1;
      sz_2: sz_bytes = 3'h2;
      sz_4: sz_bytes = 3'h4;
      default: sz_bytes = 3'h0;
    endcase
  endfunction : sz_bytes

  // immediate length from opcode: only the common forms carry one
  function automatic fld_size_t imm_size(input logic [7:0] op, input logic two, input logic op32);
    fld_size_t full;
    full = op32 ? sz_4 : sz_2;
    imm_size = sz_none;
    if (!two) begin
      if (op == `OP_GRP80 || op == 8'h82 || op == 8'h83 || op == 8'hc6 || op[7:3] == 5'h16) imm_size = sz_1;
      if (op == 8'h81 || op == 8'hc7 || op[7:3] == 5'h17 || op == 8'h69) imm_size = full;
      if (op[7:6] == 2'h0 && op[2:1] == 2'h2) imm_size = op[0] ? full : sz_1;
    end else if (op == 8'hba) imm_size = sz_1;
  endfunction : imm_size

  function automatic logic needs_modrm(input logic [7:0] op, input logic two);
    if (two) needs_modrm = (op[7:4] != 4'h8) && (op[7:3] != 5'h19);
    else needs_modrm = (op[7:6] == 2'h0 && op[2] == 1'b0) || op[7:4] == 4'h8 || op == 8'h69 || op == 8'h6b ||
                       op == 8'hc6 || op == 8'hc7 || op[7:4] == 4'hd || op == 8'hf6 || op == 8'hf7 ||
                       op == 8'hfe || op == 8'hff || op == 8'h62 || op == 8'h63;
  endfunction : needs_modrm

  assign modrm_b = {st.d.mode, st.d.op_ext, st.d.rm};
  assign sib_b = st.sib;

  modrm_decode u_modrm (
    .modrm(modrm_b),
    .sib(sib_b),
    .addr32(addr32_eff),
    .seg_override(st.seg_ovr),
    .seg_override_valid(st.seg_ovr_valid),
    .has_sib(has_sib),
    .disp_size(disp_size),
    .seg(seg),
    .index_used(index_used),
    .base_used(base_used),
    .ea_undefined(ea_undef)
  );

  // sizes follow the live default so the first instruction after reset is right too
  assign op32_eff = default_32 ^ st.opsz_flip;
  assign addr32_eff = default_32 ^ st.adsz_flip;

  // settling phases take no byte, so nothing is swallowed while they run
  always_comb begin
    case (st.phase)
      st_prefix, st_op2, st_modrm: byte_ready = 1'b1;
      st_sib: byte_ready = has_sib;
      st_disp, st_imm: byte_ready = (st.left != 3'h0);
      default: byte_ready = 1'b0;
    endcase
  end
  assign take = byte_valid && byte_ready;
  assign out_s.valid = (st.phase == st_emit);
  assign out_s.data = st.d;

  dec_skid_buffer #(.DEPTH(2)) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_s(out_s),
    .out_valid(dec_valid),
    .out_ready(dec_ready),
    .out_data(dec_data)
  );

  // ----------------------------------------------------------------
  // byte sequencing
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] b;
    fld_size_t isz;
    b = byte_data;
    isz = sz_none;
    next_st = st;
    if (take) begin
      next_st.d.length = 4'(st.d.length + 4'h1);
    end
    if (take && st.d.length == `MAX_INSN_LEN) begin
      // a sixteenth byte ends the word at once; the tail stays in the stream
      next_st.d.fault = 1'b1;
      next_st.d.error_code = `GP_ERROR_CODE;
      next_st.phase = st_emit;
    end else begin
      case (st.phase)
        st_prefix: begin
          if (take) begin
            case (b)
              `PFX_ES: {next_st.seg_ovr, next_st.seg_ovr_valid} = {`SEG_ES, 1'b1};
              `PFX_CS: {next_st.seg_ovr, next_st.seg_ovr_valid} = {`SEG_CS, 1'b1};
              `PFX_SS: {next_st.seg_ovr, next_st.seg_ovr_valid} = {`SEG_SS, 1'b1};
              `PFX_DS: {next_st.seg_ovr, next_st.seg_ovr_valid} = {`SEG_DS, 1'b1};
              `PFX_FS: {next_st.seg_ovr, next_st.seg_ovr_valid} = {`SEG_FS, 1'b1};
              `PFX_GS: {next_st.seg_ovr, next_st.seg_ovr_valid} = {`SEG_GS, 1'b1};
              `PFX_OPSZ: next_st.opsz_flip = 1'b1;
              `PFX_ADSZ: next_st.adsz_flip = 1'b1;
              `PFX_LOCK: next_st.d.lock = 1'b1;
              `PFX_REPEAT_WHILE_UNEQUAL: next_st.d.repeat_while_unequal = 1'b1;
              `PFX_REPE: next_st.d.repeat_while_equal = 1'b1;
              `OP_ESCAPE: begin
                next_st.d.opcode0 = b;
                next_st.d.two_byte = 1'b1;
                next_st.phase = st_op2;
              end
              default: begin
                next_st.d.opcode0 = b;
                next_st.d.width = b[0];
                next_st.d.dir = b[1];
                // only the 80-83 immediate group and the 6a/6b forms carry a sign-extension bit
                next_st.d.sign_ext = b[1] && (b[7:2] == 6'h20 || b[7:2] == 6'h1a);
                next_st.d.reg_sel = b[2:0];
                if (needs_modrm(b, 1'b0)) begin
                  next_st.phase = st_modrm;
                end else begin
                  isz = imm_size(b, 1'b0, op32_eff);
                  next_st.left = sz_bytes(isz);
                  next_st.imm_len = sz_bytes(isz);
                  next_st.phase = st_imm;
                end
              end
            endcase
          end
        end
        st_op2: begin
          if (take) begin
            next_st.d.opcode1 = b;
            next_st.d.width = b[0];
            next_st.d.dir = b[1];
            if (needs_modrm(b, 1'b1)) begin
              next_st.phase = st_modrm;
            end else begin
              isz = imm_size(b, 1'b1, op32_eff);
              next_st.left = sz_bytes(isz);
              next_st.imm_len = sz_bytes(isz);
              next_st.phase = st_imm;
            end
          end
        end
        st_modrm: begin
          if (take) begin
            next_st.d.mode = b[7:6];
            next_st.d.op_ext = b[5:3];
            next_st.d.reg_sel = b[5:3];
            next_st.d.spec_sel = b[5:3];
            next_st.d.seg_select_wide = b[5:3];
            next_st.d.seg_select_narrow = b[4:3];
            next_st.d.rm = b[2:0];
            next_st.d.rm_is_reg = (b[7:6] == `MOD_REG);
            next_st.phase = st_sib;
          end
        end
        st_sib: begin
          if (!has_sib) begin
            next_st.phase = st_dsize;
          end else if (take) begin
            next_st.sib = b;
            next_st.phase = st_dsize;
          end
        end
        st_dsize: begin
          // settling cycle: a sib base of 101 changes the displacement size
          next_st.left = sz_bytes(disp_size);
          next_st.shift = 2'h0;
          next_st.d.disp = '0;
          next_st.phase = st_disp;
        end
        st_disp: begin
          if (st.left == 3'h0) begin
            if (disp_size == sz_1) next_st.d.disp = {{24{st.d.disp[7]}}, st.d.disp[7:0]};
            isz = imm_size(st.d.two_byte ? st.d.opcode1 : st.d.opcode0, st.d.two_byte, op32_eff);
            next_st.left = sz_bytes(isz);
            next_st.imm_len = sz_bytes(isz);
            next_st.shift = 2'h0;
            next_st.d.imm = '0;
            next_st.phase = st_imm;
          end else if (take) begin
            next_st.d.disp[{st.shift, 3'h0} +: 8] = b;
            next_st.shift = 2'(st.shift + 2'h1);
            next_st.left = 3'(st.left - 3'h1);
          end
        end
        st_imm: begin
          if (st.left == 3'h0) begin
            if (st.imm_len == 3'h1 && st.d.sign_ext) begin
              next_st.d.imm = op32_eff ? {{24{st.d.imm[7]}}, st.d.imm[7:0]} :
                              {16'h0000, {8{st.d.imm[7]}}, st.d.imm[7:0]};
            end
            // every derived field is frozen here, so the emitted word is all flops
            next_st.d.op32 = op32_eff;
            next_st.d.addr32 = addr32_eff;
            next_st.d.has_sib = has_sib;
            next_st.d.scale = st.sib[7:6];
            next_st.d.index = st.sib[5:3];
            next_st.d.base = has_sib ? st.sib[2:0] : st.d.rm;
            next_st.d.index_used = index_used;
            next_st.d.base_used = base_used;
            next_st.d.ea_undefined = ea_undef;
            next_st.d.seg = seg;
            next_st.d.reg_is_byte = ~st.d.width;
            next_st.d.seg_wide_valid = (st.d.seg_select_wide[2:1] != 2'h3);
            next_st.d.ctl_ok = (st.d.spec_sel == 3'h0) || (st.d.spec_sel == 3'h2) || (st.d.spec_sel == 3'h3);
            next_st.d.dbg_ok = (st.d.spec_sel[2:1] != 2'h2);
            next_st.d.tst_ok = (st.d.spec_sel >= 3'h3);
            next_st.phase = st_emit;
          end else if (take) begin
            next_st.d.imm[{st.shift, 3'h0} +: 8] = b;
            next_st.shift = 2'(st.shift + 2'h1);
            next_st.left = 3'(st.left - 3'h1);
          end
        end
        st_emit: begin
          if (out_s.ready) begin
            // nothing of this word's prefixes survives into the next
            next_st = '0;
            next_st.phase = st_prefix;
          end
        end
        default: next_st.phase = st_prefix;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) st <= '0;
    else st <= next_st;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  AST_LEN_STEP: assert property (take |=> st.d.length == 4'($past(st.d.length) + 4'h1))
    else $error("length did not count a taken byte");
  AST_OVERLONG: assert property (take && st.d.length == `MAX_INSN_LEN |=> st.phase == st_emit && st.d.fault)
    else $error("overlong instruction not faulted");
  AST_NO_TAKE_EMIT: assert property (st.phase == st_emit |-> !byte_ready)
    else $error("byte offered acceptance while emitting");
  AST_PFX_CLEAR: assert property (out_s.valid && out_s.ready |=> !st.d.lock && !st.seg_ovr_valid && !st.opsz_flip)
    else $error("prefix state survived the instruction");
  AST_OP_SIZE: assert property (out_s.valid && !st.d.fault |-> st.d.op32 == (default_32 ^ st.opsz_flip))
    else $error("operand size not inverted by prefix");
  AST_UNDEF_EA: assert property (out_s.valid && st.d.has_sib && st.d.index == `IDX_NONE && st.d.scale != 2'h0 |-> st.d.ea_undefined)
    else $error("scaled absent index not flagged");
  AST_BYTE_REG: assert property (out_s.valid && !st.d.fault |-> st.d.reg_is_byte == !st.d.width)
    else $error("byte register select wrong");

  COV_FAULT: cover property (out_s.valid && out_s.ready && st.d.fault);
  COV_SIB: cover property (out_s.valid && out_s.ready && st.d.has_sib);
  COV_STALL: cover property (out_s.valid && !out_s.ready);
endmodule : insn_field_decoder

// *** verification/prefetch_model.sv ***
// prefetch queue feeding bytes and execution pipeline taking decoded words
`timescale 1ns/1ps
module prefetch_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic stall,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic [7:0] byte_data,
  input wire logic dec_valid,
  output logic dec_ready
);
  logic [7:0] q[$];
  initial begin
    byte_valid = 1'b0;
    byte_data = 8'h00;
    dec_ready = 1'b0;
  end
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  // bytes are offered back to back; an idle line inverts byte_data on every cycle, starting from the last byte
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      byte_valid <= 1'b0;
      dec_ready <= 1'b0;
    end else begin
      dec_ready <= !stall;
      if (byte_valid && byte_ready) begin
        void'(q.pop_front());
      end
      if (q.size() > 0) begin
        byte_valid <= 1'b1;
        byte_data <= q[0];
      end else begin
        byte_valid <= 1'b0;
        byte_data <= ~byte_data;
      end
    end
  end
endmodule : prefetch_model

// *** verification/x86_instruction_field_decoder_tb.sv ***
// self-checking testbench for the instruction field decoder
`timescale 1ns/1ps
module x86_instruction_field_decoder_tb;
  import insn_decoder_pkg::*;
  logic ref_clk, resetn, default_32, stall, byte_valid, byte_ready, dec_valid, dec_ready;
  logic [7:0] byte_data;
  decoded_t dec_data, d;
  int fails, num_checks;
  insn_field_decoder dut_u (.ref_clk(ref_clk), .resetn(resetn), .default_32(default_32),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data),
    .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_data(dec_data));
  prefetch_model part_u (.ref_clk(ref_clk), .resetn(resetn), .stall(stall), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_data(byte_data), .dec_valid(dec_valid), .dec_ready(dec_ready));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask : check
  task automatic get;
    int n;
    // judged off the edge, where outputs have settled; the word moves at the next rise
    for (n = 0; n < 400; n++) begin
      @(negedge ref_clk);
      if (dec_valid === 1'b1 && dec_ready === 1'b1) break;
    end
    if (n == 400) begin
      fails++;
      wrap_up();
    end
    d = dec_data;
    @(posedge ref_clk);
  endtask : get
  task automatic xfer(input logic [7:0] b[$]);
    foreach (b[i]) part_u.push(b[i]);
    get();
  endtask : xfer
  task automatic mode(input logic m);
    default_32 <= m;
    @(posedge ref_clk);
  endtask : mode
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_prefix;
    logic [7:0] pf[6];
    pf = '{8'h26, 8'h2e, 8'h36, 8'h3e, 8'h64, 8'h65};
    mode(1'b1);
    xfer({8'h90});
    check("len", d.length, 1);
    check("fault", d.fault, 0);
    xfer({8'h2e, 8'h66, 8'h67, 8'hf0, 8'hf3, 8'h8b, 8'h07});
    check("seg", d.seg, 1);
    check("op32", d.op32, 0);
    check("addr32", d.addr32, 0);
    check("lock", d.lock, 1);
    check("rep_eq", d.repeat_while_equal, 1);
    check("len", d.length, 7);
    xfer({8'h90});
    check("lock", d.lock, 0);
    check("rep_eq", d.repeat_while_equal, 0);
    check("op32", d.op32, 1);
    xfer({8'hf2, 8'ha6});
    check("rep_ne", d.repeat_while_unequal, 1);
    mode(1'b0);
    foreach (pf[i]) begin
      xfer({pf[i], 8'h8b, 8'h07});
      check("seg", d.seg, i);
    end
    $display("prefix test done");
  endtask : t_prefix
  task automatic t_fields;
    mode(1'b1);
    xfer({8'h80, 8'hf8, 8'h05});
    check("ext", d.op_ext, 7);
    check("rm_reg", d.rm_is_reg, 1);
    check("width", d.width, 0);
    check("imm", d.imm, 5);
    check("len", d.length, 3);
    xfer({8'h89, 8'hd8});
    check("dir", d.dir, 0);
    check("reg", d.reg_sel, 3);
    check("rm", d.rm, 0);
    xfer({8'h8a, 8'h07});
    check("dir", d.dir, 1);
    check("bytereg", d.reg_is_byte, 1);
    xfer({8'h83, 8'hc0, 8'hff});
    check("sext", d.sign_ext, 1);
    check("imm", d.imm, 32'hffffffff);
    $display("field test done");
  endtask : t_fields
  task automatic t_addr;
    mode(1'b0);
    xfer({8'h8b, 8'h46, 8'h08});
    check("seg", d.seg, 2);
    check("disp", d.disp, 8);
    xfer({8'h8b, 8'h06, 8'h34, 8'h12});
    check("seg", d.seg, 3);
    check("disp", d.disp, 32'h1234);
    mode(1'b1);
    xfer({8'h8b, 8'h44, 8'h8d, 8'h10});
    check("sib", d.has_sib, 1);
    check("scale", d.scale, 2);
    check("base", d.base, 5);
    check("seg", d.seg, 2);
    check("len", d.length, 4);
    // scale 00 with no index keeps the far side within its own rule
    xfer({8'h8b, 8'h04, 8'h25, 8'h44, 8'h33, 8'h22, 8'h11});
    check("idx", d.index_used, 0);
    check("base", d.base_used, 0);
    check("disp", d.disp, 32'h11223344);
    xfer({8'h8b, 8'h04, 8'h65, 8'h00, 8'h00, 8'h00, 8'h00});
    check("undef", d.ea_undefined, 1);
    xfer({8'h8b, 8'h05, 8'h78, 8'h56, 8'h34, 8'h12});
    check("sib", d.has_sib, 0);
    check("disp", d.disp, 32'h12345678);
    $display("address test done");
  endtask : t_addr
  task automatic t_special;
    xfer({8'h0f, 8'h20, 8'hc0});
    check("two", d.two_byte, 1);
    check("ctl", d.ctl_ok, 1);
    xfer({8'h0f, 8'h22, 8'hc8});
    check("spec", d.spec_sel, 1);
    check("ctl", d.ctl_ok, 0);
    xfer({8'h0f, 8'h21, 8'hf0});
    check("dbg", d.dbg_ok, 1);
    xfer({8'h0f, 8'h26, 8'he8});
    check("tst", d.tst_ok, 1);
    xfer({8'h8e, 8'hd8});
    check("sw", d.seg_select_wide, 3);
    check("swv", d.seg_wide_valid, 1);
    xfer({8'h8e, 8'hf0});
    check("swv", d.seg_wide_valid, 0);
    $display("special test done");
  endtask : t_special
  task automatic t_stall;
    logic [7:0] sb[4];
    sb = '{8'hf0, 8'h90, 8'h41, 8'h90};
    stall <= 1'b1;
    foreach (sb[i]) part_u.push(sb[i]);
    repeat (40) @(posedge ref_clk);
    check("held", dec_valid, 1);
    check("blocked", byte_ready, 0);
    stall <= 1'b0;
    get();
    check("lock", d.lock, 1);
    get();
    check("op", d.opcode0, 8'h41);
    get();
    check("len", d.length, 1);
    $display("stall test done");
  endtask : t_stall
  task automatic t_length;
    mode(1'b0);
    repeat (11) part_u.push(8'h3e);
    xfer({8'h8b, 8'h06, 8'h34, 8'h12});
    check("len", d.length, 15);
    check("fault", d.fault, 0);
    repeat (13) part_u.push(8'h3e);
    xfer({8'h8b, 8'h06, 8'h34, 8'h12});
    check("fault", d.fault, 1);
    check("code", d.error_code, 0);
    $display("length test done");
  endtask : t_length
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    default_32 = 1'b0;
    stall = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_prefix();
    t_fields();
    t_addr();
    t_special();
    t_stall();
    // a faulted stream is left behind, so this goes last
    t_length();
    wrap_up();
  end
endmodule : x86_instruction_field_decoder_tb
